// [design/acs_defines.svh]
// Constants for the administrative command status block
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_ADDR_W 8
`define ACS_OFF_STATUS 8'hA8
`define ACS_OFF_QCOUNT 8'hB0
`define ACS_QCOUNT_RESET 8'h08

`define ACS_NUM_WQ 8
`define ACS_NUM_ENG 4
`define ACS_NUM_GRP 4

`define ACS_ST_ACTIVE 31
`define ACS_ST_RES_HI 23
`define ACS_ST_RES_LO 8
`define ACS_ST_ERR_HI 7
`define ACS_ST_ERR_LO 0

`define ACS_OP_WQIDX_HI 7
`define ACS_OP_GRP_HI 19
`define ACS_OP_GRP_LO 16
`define ACS_OP_MAP_HI 15
`define ACS_OP_IDX_HI 15

`define ACS_ERR_OK 8'h00
`define ACS_ERR_BADCMD 8'h01
`define ACS_ERR_BADWQ 8'h02
`define ACS_ERR_HWFAULT 8'h03
`define ACS_ERR_DEV_NOT_DIS 8'h10
`define ACS_ERR_CFG_UNSPEC 8'h11
`define ACS_ERR_BME_OFF 8'h12
`define ACS_ERR_PRALLOC 8'h13
`define ACS_ERR_WQ_SUM 8'h14
`define ACS_ERR_GRP_EMPTY 8'h15
`define ACS_ERR_GRP_WQ 8'h16
`define ACS_ERR_GRP_ENG 8'h17
`define ACS_ERR_BW_TOKEN 8'h18
`define ACS_ERR_DEV_NOT_EN 8'h20
`define ACS_ERR_WQ_NOT_DIS 8'h21
`define ACS_ERR_WQ_SIZE0 8'h22
`define ACS_ERR_WQ_PRIO0 8'h23
`define ACS_ERR_WQ_MODE 8'h24
`define ACS_ERR_WQ_BOF 8'h25
`define ACS_ERR_WQ_PASID 8'h26
`define ACS_ERR_WQ_BATCH 8'h27
`define ACS_ERR_WQ_XFER 8'h28
`define ACS_ERR_WQ_PRIV 8'h2A
`define ACS_ERR_DDEV_NOT_EN 8'h31
`define ACS_ERR_DWQ_NOT_EN 8'h32
`define ACS_ERR_IH_INDEX 8'h41
`define ACS_ERR_IH_NONE 8'h42

`endif

// [design/acs_pkg.sv]
// Types for the administrative command status block
package acs_pkg;

    typedef enum logic [4:0] {
        ACS_CMD_EN_DEV = 5'h01,
        ACS_CMD_DIS_DEV = 5'h02,
        ACS_CMD_DRAIN_ALL = 5'h03,
        ACS_CMD_ABORT_ALL = 5'h04,
        ACS_CMD_RESET_DEV = 5'h05,
        ACS_CMD_EN_WQ = 5'h06,
        ACS_CMD_DIS_WQ = 5'h07,
        ACS_CMD_DRAIN_WQ = 5'h08,
        ACS_CMD_ABORT_WQ = 5'h09,
        ACS_CMD_RESET_WQ = 5'h0A,
        ACS_CMD_DRAIN_PASID = 5'h0B,
        ACS_CMD_ABORT_PASID = 5'h0C,
        ACS_CMD_REQ_IH = 5'h0D
    } acs_cmd_e;

    typedef enum logic [1:0] {
        ACS_ST_IDLE = 2'b00,
        ACS_ST_CHECK = 2'b01,
        ACS_ST_EXEC = 2'b10
    } acs_state_e;

endpackage : acs_pkg

// [design/acs_command_status.sv]
// Administrative command status tracking and command validity checks
// Overview of operation
// - In-progress flag set to one when a command write is accepted.
// - Error and result fields carry no promise while a command runs.
// - Completion clears the flag and shows outcome; flag is zero after reset.
// - Error code 0x00 success, 0x01 bad command, 0x02 bad queue index.
// - Platform or internal hardware fault reports 0x03.
// - Codes 0x04 to 0x0F never produced; 0x10 upward command specific.
// - Result holds interrupt handle only after successful handle request.
// - Enable device: 0x10 not disabled, 0x11 config fault, 0x12 no mastering.
// - Enable device: 0x13 bad page request allocation, 0x14 queue sizes too big.
// - Enable device: 0x15 group with queues but no engines, or reverse.
// - Enable device: 0x16 queue in several groups, orphan queue, reserved bits.
// - Enable device: 0x17 engine in several groups or reserved engine bits.
// - Enable device: 0x18 invalid global or group bandwidth token settings.
// - Enable queue: 0x20, 0x21, 0x22, 0x23 for device, state, size, priority.
// - Enable queue does not check queue size range.
// - Enable queue: 0x24 when requested mode lacks capability support.
// - Enable queue: 0x25 block-on-fault without support or page requests.
// - Enable queue: 0x26 PASID off in shared mode or on without capability.
// - Enable queue: 0x27 batch size out of range, 0x28 transfer too large.
// - Enable queue: 0x2A privileged dedicated PASID queue without privilege.
// - Disable device 0x31 when not enabled; disable queue 0x32 if any not enabled.
// - Handle request: 0x41 bad table index, 0x42 no handle available.
`include "acs_defines.svh"

module acs_command_status
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [`ACS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Command submission
    input wire logic cmd_write,
    input wire logic [4:0] cmd_code,
    input wire logic [19:0] cmd_operand,
    output logic sw_error_pulse,
    // Device state and configuration
    input wire logic device_enabled,
    input wire logic device_disabled,
    input wire logic bus_master_enable,
    input wire logic page_req_alloc_ok,
    input wire logic wq_size_sum_ok,
    input wire logic bw_token_ok,
    input wire logic config_fault,
    input wire logic intr_handle_cap,
    input wire logic [15:0] intr_table_size,
    input wire logic [`ACS_NUM_WQ-1:0] wq_enabled,
    input wire logic [`ACS_NUM_WQ-1:0] wq_size_nonzero,
    input wire logic [`ACS_NUM_GRP*`ACS_NUM_WQ-1:0] grp_wq_set,
    input wire logic [`ACS_NUM_GRP*`ACS_NUM_ENG-1:0] grp_eng_set,
    input wire logic [`ACS_NUM_ENG-1:0] eng_present,
    // Selected queue configuration, checked in the same cycle that sel_wq_index first shows the new index
    output logic [`ACS_OP_WQIDX_HI:0] sel_wq_index,
    input wire logic sel_wq_disabled,
    input wire logic sel_wq_priority_zero,
    input wire logic sel_wq_mode,
    input wire logic sel_wq_bof,
    input wire logic sel_wq_pasid_en,
    input wire logic sel_wq_priv,
    input wire logic [7:0] sel_wq_max_batch,
    input wire logic [7:0] sel_wq_max_xfer,
    input wire logic cap_shared_mode,
    input wire logic cap_dedicated_mode,
    input wire logic cap_block_on_fault,
    input wire logic page_req_enable,
    input wire logic pasid_cap_enable,
    input wire logic pasid_priv_enable,
    input wire logic [7:0] max_batch_supported,
    input wire logic [7:0] max_xfer_supported,
    // Command execution
    output logic exec_start,
    output logic [4:0] exec_code,
    output logic [19:0] exec_operand,
    input wire logic exec_done,
    input wire logic exec_fault,
    input wire logic exec_no_handle,
    input wire logic [15:0] exec_handle
);

    acs_state_e state_ff;
    acs_state_e nxt_state;
    logic active_ff;
    logic [7:0] err_ff;
    logic [15:0] result_ff;
    logic [4:0] code_ff;
    logic [19:0] operand_ff;
    logic [7:0] qcount_ff;
    logic exec_start_ff;
    logic sw_error_ff;
    logic [31:0] rdata_ff;
    logic accept;
    logic [7:0] check_err;
    logic [`ACS_NUM_WQ-1:0] wq_multi;
    logic [`ACS_NUM_WQ-1:0] wq_orphan;
    logic [`ACS_NUM_ENG-1:0] eng_multi;
    logic [`ACS_NUM_GRP-1:0] grp_empty;
    logic [`ACS_NUM_GRP-1:0] grp_wq_rsvd;
    logic [`ACS_NUM_GRP-1:0] grp_eng_rsvd;
    logic [`ACS_NUM_WQ-1:0] wq_in_range;
    logic [`ACS_NUM_WQ-1:0] dis_sel;
    logic wq_idx_bad;
    logic grp_idx_bad;

    // Writes while busy are dropped, never queued
    assign accept = cmd_write && !active_ff;

    // Queues that exist under the current queue count
    generate
        for (genvar q = 0; q < `ACS_NUM_WQ; q++) begin : g_wq
            logic [`ACS_NUM_GRP-1:0] memb;
            for (genvar g = 0; g < `ACS_NUM_GRP; g++) begin : g_m
                assign memb[g] = grp_wq_set[g*`ACS_NUM_WQ+q];
            end
            assign wq_in_range[q] = (8'(q) < qcount_ff);
            assign wq_multi[q] = ($countones(memb) > 1);
            assign wq_orphan[q] = wq_size_nonzero[q] && (memb == '0);
        end
        // Engines claimed by more than one group
        for (genvar e = 0; e < `ACS_NUM_ENG; e++) begin : g_eng
            logic [`ACS_NUM_GRP-1:0] memb;
            for (genvar g = 0; g < `ACS_NUM_GRP; g++) begin : g_m
                assign memb[g] = grp_eng_set[g*`ACS_NUM_ENG+e];
            end
            assign eng_multi[e] = ($countones(memb) > 1);
        end
        // Per-group emptiness and reserved bit checks
        for (genvar g = 0; g < `ACS_NUM_GRP; g++) begin : g_grp
            logic [`ACS_NUM_WQ-1:0] wqs;
            logic [`ACS_NUM_ENG-1:0] engs;
            assign wqs = grp_wq_set[g*`ACS_NUM_WQ +: `ACS_NUM_WQ];
            assign engs = grp_eng_set[g*`ACS_NUM_ENG +: `ACS_NUM_ENG];
            assign grp_empty[g] = ((wqs != '0) != (engs != '0));
            assign grp_wq_rsvd[g] = ((wqs & ~wq_in_range) != '0);
            assign grp_eng_rsvd[g] = ((engs & ~eng_present) != '0);
        end
    endgenerate

    // Queue index checks for single-queue and bitmap commands
    assign wq_idx_bad = (operand_ff[`ACS_OP_WQIDX_HI:0] >= qcount_ff);
    assign grp_idx_bad = ({operand_ff[`ACS_OP_GRP_HI:`ACS_OP_GRP_LO], 4'h0} >= qcount_ff)
        || (operand_ff[`ACS_OP_GRP_HI:`ACS_OP_GRP_LO] != 4'h0
            && `ACS_NUM_WQ <= 16);
    assign dis_sel = operand_ff[`ACS_NUM_WQ-1:0];
    assign sel_wq_index = operand_ff[`ACS_OP_WQIDX_HI:0];

    // Checks run in priority order; first failing check wins
    always_comb begin
        check_err = `ACS_ERR_OK;
        case (code_ff)
            ACS_CMD_EN_DEV: begin
                if (!device_disabled) check_err = `ACS_ERR_DEV_NOT_DIS;
                else if (!bus_master_enable) check_err = `ACS_ERR_BME_OFF;
                else if (!page_req_alloc_ok) check_err = `ACS_ERR_PRALLOC;
                else if (!wq_size_sum_ok) check_err = `ACS_ERR_WQ_SUM;
                else if (grp_empty != '0) check_err = `ACS_ERR_GRP_EMPTY;
                else if (wq_multi != '0 || wq_orphan != '0 || grp_wq_rsvd != '0)
                    check_err = `ACS_ERR_GRP_WQ;
                else if (eng_multi != '0 || grp_eng_rsvd != '0)
                    check_err = `ACS_ERR_GRP_ENG;
                else if (!bw_token_ok) check_err = `ACS_ERR_BW_TOKEN;
                else if (config_fault) check_err = `ACS_ERR_CFG_UNSPEC;
            end
            ACS_CMD_EN_WQ: begin
                // Size range is deliberately not checked here
                if (wq_idx_bad) check_err = `ACS_ERR_BADWQ;
                else if (!device_enabled) check_err = `ACS_ERR_DEV_NOT_EN;
                else if (!sel_wq_disabled) check_err = `ACS_ERR_WQ_NOT_DIS;
                else if (!wq_size_nonzero[sel_wq_index[2:0]])
                    check_err = `ACS_ERR_WQ_SIZE0;
                else if (sel_wq_priority_zero) check_err = `ACS_ERR_WQ_PRIO0;
                else if ((!sel_wq_mode && !cap_shared_mode)
                    || (sel_wq_mode && !cap_dedicated_mode))
                    check_err = `ACS_ERR_WQ_MODE;
                else if (sel_wq_bof && (!cap_block_on_fault || !page_req_enable))
                    check_err = `ACS_ERR_WQ_BOF;
                else if ((!sel_wq_pasid_en && !sel_wq_mode)
                    || (sel_wq_pasid_en && !pasid_cap_enable))
                    check_err = `ACS_ERR_WQ_PASID;
                else if (sel_wq_max_batch == 8'h00
                    || sel_wq_max_batch > max_batch_supported)
                    check_err = `ACS_ERR_WQ_BATCH;
                else if (sel_wq_max_xfer > max_xfer_supported)
                    check_err = `ACS_ERR_WQ_XFER;
                else if (sel_wq_mode && sel_wq_pasid_en && sel_wq_priv
                    && !pasid_priv_enable)
                    check_err = `ACS_ERR_WQ_PRIV;
            end
            ACS_CMD_DIS_DEV: begin
                if (!device_enabled) check_err = `ACS_ERR_DDEV_NOT_EN;
            end
            ACS_CMD_DIS_WQ: begin
                if (grp_idx_bad || (dis_sel & ~wq_in_range) != '0)
                    check_err = `ACS_ERR_BADWQ;
                else if ((dis_sel & ~wq_enabled) != '0)
                    check_err = `ACS_ERR_DWQ_NOT_EN;
            end
            ACS_CMD_DRAIN_WQ, ACS_CMD_ABORT_WQ, ACS_CMD_RESET_WQ: begin
                if (grp_idx_bad || (dis_sel & ~wq_in_range) != '0)
                    check_err = `ACS_ERR_BADWQ;
            end
            ACS_CMD_REQ_IH: begin
                // Command is reserved when the capability is absent
                if (!intr_handle_cap) check_err = `ACS_ERR_BADCMD;
                else if (operand_ff[`ACS_OP_IDX_HI:0] >= intr_table_size)
                    check_err = `ACS_ERR_IH_INDEX;
            end
            ACS_CMD_DRAIN_ALL, ACS_CMD_ABORT_ALL, ACS_CMD_RESET_DEV,
            ACS_CMD_DRAIN_PASID, ACS_CMD_ABORT_PASID: begin
                check_err = `ACS_ERR_OK;
            end
            default: begin
                check_err = `ACS_ERR_BADCMD;
            end
        endcase
    end

    // Sequencer: accept, check one cycle later, then execute
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ACS_ST_IDLE: begin
                if (accept) nxt_state = ACS_ST_CHECK;
            end
            ACS_ST_CHECK: begin
                if (check_err != `ACS_ERR_OK) nxt_state = ACS_ST_IDLE;
                else nxt_state = ACS_ST_EXEC;
            end
            ACS_ST_EXEC: begin
                if (exec_done) nxt_state = ACS_ST_IDLE;
            end
            default: begin
                nxt_state = ACS_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) state_ff <= ACS_ST_IDLE;
        else state_ff <= nxt_state;
    end

    // Busy flag: set on accept, cleared on completion
    always_ff @(posedge clk) begin
        if (reset) begin
            active_ff <= 1'b0;
        end else if (accept) begin
            active_ff <= 1'b1;
        end else if ((state_ff == ACS_ST_CHECK && check_err != `ACS_ERR_OK)
            || (state_ff == ACS_ST_EXEC && exec_done)) begin
            active_ff <= 1'b0;
        end
    end

    // Latched command for checks and execution
    always_ff @(posedge clk) begin
        if (reset) begin
            code_ff <= 5'h00;
            operand_ff <= 20'h00000;
        end else if (accept) begin
            code_ff <= cmd_code;
            operand_ff <= cmd_operand;
        end
    end

    // Outcome fields; untouched while busy so old values simply persist
    always_ff @(posedge clk) begin
        if (reset) begin
            err_ff <= `ACS_ERR_OK;
            result_ff <= 16'h0000;
        end else if (state_ff == ACS_ST_CHECK && check_err != `ACS_ERR_OK) begin
            err_ff <= check_err;
            result_ff <= 16'h0000;
        end else if (state_ff == ACS_ST_EXEC && exec_done) begin
            if (exec_fault) begin
                err_ff <= `ACS_ERR_HWFAULT;
                result_ff <= 16'h0000;
            end else if (code_ff == ACS_CMD_REQ_IH && exec_no_handle) begin
                err_ff <= `ACS_ERR_IH_NONE;
                result_ff <= 16'h0000;
            end else begin
                err_ff <= `ACS_ERR_OK;
                result_ff <= (code_ff == ACS_CMD_REQ_IH) ? exec_handle : 16'h0000;
            end
        end
    end

    // Execution strobe, one cycle, only for commands that passed checks
    always_ff @(posedge clk) begin
        if (reset) exec_start_ff <= 1'b0;
        else exec_start_ff <= (state_ff == ACS_ST_CHECK) && (check_err == `ACS_ERR_OK);
    end

    // Dropped writes reported to the error log
    always_ff @(posedge clk) begin
        if (reset) sw_error_ff <= 1'b0;
        else sw_error_ff <= cmd_write && active_ff;
    end

    // Queue count register sets the valid index range
    always_ff @(posedge clk) begin
        if (reset) qcount_ff <= `ACS_QCOUNT_RESET;
        else if (reg_write && reg_addr == `ACS_OFF_QCOUNT) qcount_ff <= reg_wdata[7:0];
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_read) begin
            case (reg_addr)
                `ACS_OFF_STATUS: begin
                    rdata_ff <= 32'h00000000;
                    rdata_ff[`ACS_ST_ACTIVE] <= active_ff;
                    rdata_ff[`ACS_ST_RES_HI:`ACS_ST_RES_LO] <= result_ff;
                    rdata_ff[`ACS_ST_ERR_HI:`ACS_ST_ERR_LO] <= err_ff;
                end
                `ACS_OFF_QCOUNT: rdata_ff <= {24'h000000, qcount_ff};
                default: rdata_ff <= 32'h00000000;
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_ff;
    assign sw_error_pulse = sw_error_ff;
    assign exec_start = exec_start_ff;
    assign exec_code = code_ff;
    assign exec_operand = operand_ff;

endmodule : acs_command_status

// [verif/acs_command_status_properties.sv]
// Port-level property checker for the command status block
`include "acs_defines.svh"

module acs_command_status_checker
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`ACS_ADDR_W-1:0] reg_addr,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic cmd_write,
    input wire logic [19:0] cmd_operand,
    input wire logic sw_error_pulse,
    input wire logic [`ACS_OP_WQIDX_HI:0] sel_wq_index,
    input wire logic exec_start,
    input wire logic exec_done
);
    logic busy_ff, started_ff, hold_ff;
    logic [1:0] since_ff;
    logic acc, rd_st, busy_sure, idle_sure;

    // Port view of the busy flag, trusted only where timing is sure
    assign acc = cmd_write && !busy_ff;
    assign rd_st = reg_read && (reg_addr == `ACS_OFF_STATUS);
    assign busy_sure = busy_ff && (since_ff == 2'd0 || started_ff) && !exec_done;
    assign idle_sure = !busy_ff && !cmd_write;
    assign hold_ff = since_ff == 2'd2 && !started_ff && !exec_start;

    // A failed check may end a command one edge early, so idle is assumed late
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_ff <= 1'b0;
            started_ff <= 1'b0;
            since_ff <= 2'd3;
        end else begin
            busy_ff <= acc || (busy_ff && !exec_done && !hold_ff);
            started_ff <= !acc && (exec_start || (started_ff && !exec_done));
            since_ff <= acc ? 2'd0 : (since_ff == 2'd3 ? 2'd3 : since_ff + 2'd1);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    active_set_a: assert property (rd_st && busy_sure |=> reg_rdata[31])
        else $error("status read while busy shows flag low");
    active_clear_a: assert property (rd_st && idle_sure |=> !reg_rdata[31])
        else $error("status read while idle shows flag high");
    code_gap_a: assert property (rd_st && idle_sure |=>
        reg_rdata[7:4] != 4'h0 || reg_rdata[3:0] < 4'h4) else $error("unused error code");
    result_fail_a: assert property (rd_st && idle_sure |=>
        reg_rdata[7:0] == 8'h00 || reg_rdata[23:8] == 16'h0000) else $error("result beside error");
    status_hold_a: assert property (rd_st && idle_sure && $past(rd_st && idle_sure, 2)
        && !$past(cmd_write) |=> reg_rdata == $past(reg_rdata, 2)) else $error("idle status changed");
    start_delay_a: assert property (exec_start |-> $past(acc, 2))
        else $error("execution start not two cycles after accept");
    busy_drop_a: assert property (cmd_write && busy_sure |=> sw_error_pulse ##1 !exec_start)
        else $error("write while busy not dropped and flagged");
    drop_cause_a: assert property (sw_error_pulse |-> $past(cmd_write && busy_ff))
        else $error("error pulse without a write while busy");
    queue_select_a: assert property (acc |=> sel_wq_index == $past(cmd_operand[7:0]))
        else $error("queue select not taken from operand");

    cover property (acc ##2 exec_start);
    cover property (cmd_write && busy_sure ##1 sw_error_pulse);
    cover property (rd_st && idle_sure ##1 reg_rdata[7:0] != 8'h00);
endmodule : acs_command_status_checker

bind acs_command_status acs_command_status_checker acs_command_status_checker_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cmd_write(cmd_write), .cmd_operand(cmd_operand),
    .sw_error_pulse(sw_error_pulse), .sel_wq_index(sel_wq_index),
    .exec_start(exec_start), .exec_done(exec_done)
);

// [verif/acs_command_status_test.sv]
// Self-checking bench for the command status block
`include "acs_defines.svh"
`define ACS_EXPECT(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module acs_command_status_test import acs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] c; logic [19:0] op; int f; logic [7:0] e;} acs_case_s;
    logic clk = 1'b0;
    logic reset, reg_write, reg_read, cmd_write, sw_error_pulse, exec_start, exec_fault;
    logic [7:0] reg_addr, sel_wq_index, sel_wq_max_batch, sel_wq_max_xfer;
    logic [31:0] reg_wdata, reg_rdata, grp_wq_set;
    logic [4:0] cmd_code, exec_code;
    logic [19:0] cmd_operand, exec_operand;
    logic device_enabled, device_disabled, bus_master_enable, page_req_alloc_ok;
    logic wq_size_sum_ok, bw_token_ok, config_fault, intr_handle_cap, exec_no_handle;
    logic [15:0] intr_table_size, grp_eng_set, exec_handle;
    logic [7:0] wq_enabled, wq_size_nonzero, max_batch_supported, max_xfer_supported;
    logic [3:0] eng_present;
    logic sel_wq_disabled, sel_wq_priority_zero, sel_wq_mode, sel_wq_bof, sel_wq_pasid_en;
    logic sel_wq_priv, cap_shared_mode, cap_dedicated_mode, cap_block_on_fault;
    logic page_req_enable, pasid_cap_enable, pasid_priv_enable;
    logic exec_done = 1'b0;
    int fail_count = 0, compares = 0, starts = 0, wait_cnt = 0, exec_lat = 3;
    // Code, operand, configuration fault, expected error code
    acs_case_s cases[$] = '{'{5'h01,20'h0,0,8'h00}, '{5'h01,20'h0,2,8'h11},
        '{5'h01,20'h0,1,8'h10}, '{5'h01,20'h0,3,8'h12},
        '{5'h01,20'h0,4,8'h13}, '{5'h01,20'h0,5,8'h14},
        '{5'h01,20'h0,6,8'h15}, '{5'h01,20'h0,9,8'h18},
        '{5'h01,20'h0,7,8'h16}, '{5'h01,20'h0,11,8'h16},
        '{5'h01,20'h0,8,8'h17}, '{5'h01,20'h0,10,8'h17},
        '{5'h06,20'h2,0,8'h00}, '{5'h06,20'h2,5,8'h00},
        '{5'h06,20'h8,0,8'h02}, '{5'h06,20'h2,15,8'h20},
        '{5'h06,20'h2,16,8'h21}, '{5'h06,20'h2,12,8'h22},
        '{5'h06,20'h2,17,8'h23}, '{5'h06,20'h2,18,8'h24},
        '{5'h06,20'h2,19,8'h24}, '{5'h06,20'h2,20,8'h25},
        '{5'h06,20'h2,21,8'h25}, '{5'h06,20'h2,22,8'h26},
        '{5'h06,20'h2,23,8'h26}, '{5'h06,20'h2,24,8'h27},
        '{5'h06,20'h2,25,8'h27}, '{5'h06,20'h2,26,8'h00},
        '{5'h06,20'h2,27,8'h28}, '{5'h06,20'h2,28,8'h00},
        '{5'h06,20'h2,29,8'h2A}, '{5'h02,20'h0,15,8'h31},
        '{5'h02,20'h0,0,8'h00}, '{5'h07,20'h4,13,8'h32},
        '{5'h07,20'h4,0,8'h00}, '{5'h07,20'h10004,0,8'h02},
        '{5'h0D,20'hF,0,8'h00}, '{5'h0D,20'h10,0,8'h41},
        '{5'h0D,20'hF,31,8'h42}, '{5'h0D,20'hF,14,8'h01},
        '{5'h03,20'h0,30,8'h03}, '{5'h00,20'h0,0,8'h01},
        '{5'h0E,20'h0,0,8'h01}, '{5'h1F,20'h0,0,8'h01}};

    acs_command_status acs_command_status_i (.*);

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    // Executor stand-in: one done pulse a delay set by exec_lat after each start
    always @(posedge clk) begin
        exec_done <= (wait_cnt == 1) && !reset;
        if (exec_start) begin
            starts++;
            wait_cnt <= exec_lat;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end

    // Good configuration everywhere except the one item that f breaks
    task automatic setup(input int f);
        device_enabled <= (f != 15);
        device_disabled <= (f != 1);
        bus_master_enable <= (f != 3);
        page_req_alloc_ok <= (f != 4);
        wq_size_sum_ok <= (f != 5);
        bw_token_ok <= (f != 9);
        config_fault <= (f == 2);
        intr_handle_cap <= (f != 14);
        intr_table_size <= 16'h0010;
        wq_enabled <= (f == 13) ? 8'hFB : 8'hFF;
        wq_size_nonzero <= (f == 12) ? 8'hFB : 8'hFF;
        grp_wq_set <= (f == 7) ? 32'h0000F10F : (f == 11) ? 32'h0000700F : 32'h0000F00F;
        grp_eng_set <= (f == 6) ? 16'h0001 : (f == 8) ? 16'h0031 : (f == 10) ? 16'h0025 : 16'h0021;
        eng_present <= (f == 10) ? 4'h3 : 4'hF;
        sel_wq_disabled <= (f != 16);
        sel_wq_priority_zero <= (f == 17);
        sel_wq_mode <= !(f inside {19, 22});
        sel_wq_bof <= (f inside {20, 21});
        sel_wq_pasid_en <= (f inside {19, 23, 29});
        sel_wq_priv <= (f == 29);
        sel_wq_max_batch <= (f == 24) ? 8'h00 : (f == 25) ? 8'h09 : (f == 26) ? 8'h08 : 8'h04;
        sel_wq_max_xfer <= (f == 27) ? 8'h09 : (f == 28) ? 8'h08 : 8'h04;
        cap_shared_mode <= (f != 19);
        cap_dedicated_mode <= (f != 18);
        cap_block_on_fault <= (f != 20);
        page_req_enable <= (f != 21);
        pasid_cap_enable <= (f != 23);
        pasid_priv_enable <= (f != 29);
        max_batch_supported <= 8'h08;
        max_xfer_supported <= 8'h08;
        exec_fault <= (f == 30);
        exec_no_handle <= (f == 31);
        exec_handle <= 16'h5A3C;
    endtask : setup

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask : reg_rd

    // Poll the status until the flag drops, bounded
    task automatic wait_idle(output logic [31:0] d);
        d = 32'hFFFFFFFF;
        for (int n = 0; n < 61 && d[`ACS_ST_ACTIVE] !== 1'b0; n++) reg_rd(`ACS_OFF_STATUS, d);
    endtask : wait_idle

    task automatic issue(input logic [4:0] c, input logic [19:0] op);
        cmd_code <= c;
        cmd_operand <= op;
        cmd_write <= 1'b1;
        @(posedge clk);
        cmd_write <= 1'b0;
    endtask : issue

    task automatic run_cmd(input acs_case_s k);
        logic [31:0] d, d2;
        int s0;
        s0 = starts;
        setup(k.f);
        issue(k.c, k.op);
        reg_rd(`ACS_OFF_STATUS, d);
        `ACS_EXPECT(d[31], 1'b1)
        wait_idle(d);
        `ACS_EXPECT(d[31], 1'b0)
        `ACS_EXPECT(d[7:0], k.e)
        `ACS_EXPECT(d[23:8], (k.c == 5'h0D && k.e == 8'h00) ? 16'h5A3C : 16'h0000)
        `ACS_EXPECT(starts - s0, (k.e inside {8'h00, 8'h03, 8'h42}) ? 1 : 0)
        `ACS_EXPECT({exec_code, exec_operand}, {k.c, k.op})
        reg_rd(`ACS_OFF_STATUS, d2);
        `ACS_EXPECT(d2, d)
    endtask : run_cmd

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog sized well above the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end

    // Main sequence
    initial begin
        logic [31:0] d;
        int s0;
        reset <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h00000000;
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        cmd_write <= 1'b0;
        cmd_code <= 5'h00;
        cmd_operand <= 20'h00000;
        setup(0);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        reg_rd(`ACS_OFF_STATUS, d);
        `ACS_EXPECT(d, 32'h0)
        reg_rd(`ACS_OFF_QCOUNT, d);
        `ACS_EXPECT(d, 32'h8)
        $display("test done: reset values");
        foreach (cases[i]) run_cmd(cases[i]);
        for (int c = 3; c <= 12; c++) begin
            if (!(c inside {6, 7})) run_cmd('{5'(c), 20'h0, 0, 8'h00});
        end
        $display("test done: command codes");
        // Fewer queues makes index 5 out of range
        reg_wr(`ACS_OFF_QCOUNT, 32'h4);
        reg_rd(`ACS_OFF_QCOUNT, d);
        `ACS_EXPECT(d, 32'h4)
        run_cmd('{5'h06, 20'h5, 0, 8'h02});
        run_cmd('{5'h06, 20'h3, 0, 8'h00});
        reg_wr(`ACS_OFF_QCOUNT, 32'h8);
        reg_wr(`ACS_OFF_STATUS, 32'hFFFFFFFF);
        reg_rd(`ACS_OFF_STATUS, d);
        `ACS_EXPECT(d, 32'h0)
        reg_wr(8'h40, 32'hFFFFFFFF);
        reg_rd(8'h40, d);
        `ACS_EXPECT(d, 32'h0)
        $display("test done: register access");
        // Second write lands while a slow command runs
        exec_lat = 20;
        s0 = starts;
        setup(0);
        issue(5'h03, 20'h0);
        repeat (3) @(posedge clk);
        issue(5'h01, 20'h0);
        #1;
        `ACS_EXPECT(sw_error_pulse, 1'b1)
        @(posedge clk);
        wait_idle(d);
        `ACS_EXPECT(d, 32'h0)
        `ACS_EXPECT(starts - s0, 1)
        $display("test done: write while busy");
        wrap_up();
    end
endmodule : acs_command_status_test
